// >>> rtl/receiver_stream_status_regs.sv
// Strobed register access was decided locally.
`timescale 1ns/100ps
module receiver_stream_status_regs #(
   parameter int FRAME_TIMEOUT = rx_status_pkg::FRAME_TIMEOUT_CYC,
   parameter int REC_CLK_MAX   = rx_status_pkg::REC_CLK_MAX_KHZ
) (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic      [7:0] regRdData,
   input  wire logic       burstDetect,
   input  wire logic       discSurroundDetect,
   input  wire logic       frameTick,
   output logic      [1:0] recClkRateSel,
   output logic      [3:0] refPllPreDiv,
   output logic      [5:0] refPllIntMul,
   output logic     [13:0] refPllFracMul,
   output logic            refPllCfgValid,
   output logic            irq
);
   localparam int CNT_W = 16;
   // least frame period, in sys_clk cycles, at which each multiple still fits under the pll ceiling
   localparam int THR_512 = (512 * rx_status_pkg::CLK_KHZ + REC_CLK_MAX - 1) / REC_CLK_MAX;
   localparam int THR_256 = (256 * rx_status_pkg::CLK_KHZ + REC_CLK_MAX - 1) / REC_CLK_MAX;
   localparam int THR_128 = (128 * rx_status_pkg::CLK_KHZ + REC_CLK_MAX - 1) / REC_CLK_MAX;
   localparam logic [CNT_W-1:0] TMO_CNT = CNT_W'(FRAME_TIMEOUT);

   typedef struct packed {
      logic [7:0]                    rdData;
      logic [1:0]                    nonpcm;
      logic [CNT_W-1:0]              period;
      rx_status_pkg::rate_code_e     rate;
      logic [3:0]                    pDiv;
      logic [5:0]                    jMul;
      logic [13:0]                   dFrac;
      logic [rx_status_pkg::EVT_W-1:0] evt;
      logic [rx_status_pkg::EVT_W-1:0] mask;
   } state_s;

   // reset image of the whole state; constants only, so reset never depends on live inputs
   localparam state_s RST_STATE = '{
      rdData: 8'h00,
      nonpcm: 2'b00,
      period: '0,
      rate:   rx_status_pkg::RATE_UNKNOWN,
      pDiv:   rx_status_pkg::REF_P_RST,
      jMul:   rx_status_pkg::REF_J_RST,
      dFrac:  rx_status_pkg::REF_D_RST,
      evt:    '0,
      mask:   rx_status_pkg::EVT_MASK_RST
   };

   state_s stateFf;
   state_s nxtState;
   rx_status_pkg::rate_code_e measRate;
   logic [rx_status_pkg::EVT_W-1:0] evtHit;
   logic timedOut;

   // classify the period just closed; too fast a stream cannot be served at all
   always_comb begin
      if (stateFf.period >= CNT_W'(THR_512)) begin
         measRate = rx_status_pkg::RATE_512FS;
      end else if (stateFf.period >= CNT_W'(THR_256)) begin
         measRate = rx_status_pkg::RATE_256FS;
      end else if (stateFf.period >= CNT_W'(THR_128)) begin
         measRate = rx_status_pkg::RATE_128FS;
      end else begin
         measRate = rx_status_pkg::RATE_UNKNOWN;
      end
   end

   assign timedOut = (stateFf.period >= TMO_CNT);

   // next-state logic for the whole block
   always_comb begin
      nxtState = stateFf;
      // detector flags follow the decoder every cycle, so they clear as soon as the stream changes
      nxtState.nonpcm[rx_status_pkg::BIT_BURST_FMT] = burstDetect;
      nxtState.nonpcm[rx_status_pkg::BIT_DISC_SURR] = discSurroundDetect;
      // frame period counter saturates at the timeout so a dead input reads as undetermined
      if (frameTick) begin
         nxtState.period = CNT_W'(1);
         nxtState.rate   = timedOut ? rx_status_pkg::RATE_UNKNOWN : measRate;
      end else if (timedOut) begin
         nxtState.rate = rx_status_pkg::RATE_UNKNOWN;
      end else begin
         nxtState.period = stateFf.period + CNT_W'(1);
      end
      // register writes: pll configuration, event mask and event clear; status offsets ignore writes
      if (regWrEn) begin
         unique case (regAddr)
            rx_status_pkg::OFF_REF_PLL_CFG1: begin
               nxtState.pDiv      = regWrData[7:4];
               nxtState.jMul[5:2] = regWrData[3:0];
            end
            rx_status_pkg::OFF_REF_PLL_CFG2: begin
               nxtState.jMul[1:0]  = regWrData[7:6];
               nxtState.dFrac[13:8] = regWrData[5:0];
            end
            rx_status_pkg::OFF_REF_PLL_CFG3: begin
               nxtState.dFrac[7:0] = regWrData;
            end
            rx_status_pkg::OFF_EVENT_MASK: begin
               nxtState.mask = regWrData[rx_status_pkg::EVT_W-1:0];
            end
            rx_status_pkg::OFF_EVENT_STAT: begin
               nxtState.evt = stateFf.evt & ~regWrData[rx_status_pkg::EVT_W-1:0];
            end
            default: begin
               nxtState.mask = stateFf.mask; // status registers are read-only
            end
         endcase
      end
      // a change of either detector flag or of the rate is an event; taken here to keep the next state free of loops
      evtHit[rx_status_pkg::BIT_EVT_BURST] = nxtState.nonpcm[0] != stateFf.nonpcm[0];
      evtHit[rx_status_pkg::BIT_EVT_SURR]  = nxtState.nonpcm[1] != stateFf.nonpcm[1];
      evtHit[rx_status_pkg::BIT_EVT_RATE]  = nxtState.rate != stateFf.rate;
      // events are set after the clear so a change in the clearing cycle is kept
      nxtState.evt = nxtState.evt | evtHit;
      // read data stand in the cycle after the strobe only
      nxtState.rdData = 8'h00;
      if (regRdEn) begin
         unique case (regAddr)
            rx_status_pkg::OFF_REF_PLL_CFG1: nxtState.rdData = {stateFf.pDiv, stateFf.jMul[5:2]};
            rx_status_pkg::OFF_REF_PLL_CFG2: nxtState.rdData = {stateFf.jMul[1:0], stateFf.dFrac[13:8]};
            rx_status_pkg::OFF_REF_PLL_CFG3: nxtState.rdData = stateFf.dFrac[7:0];
            rx_status_pkg::OFF_NONPCM_STAT:  nxtState.rdData = {6'h00, stateFf.nonpcm};
            rx_status_pkg::OFF_RECCLK_STAT:  nxtState.rdData = {6'h00, stateFf.rate};
            rx_status_pkg::OFF_EVENT_STAT:   nxtState.rdData = {5'h00, stateFf.evt};
            rx_status_pkg::OFF_EVENT_MASK:   nxtState.rdData = {5'h00, stateFf.mask};
            default:                         nxtState.rdData = 8'h00;
         endcase
      end
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stateFf <= RST_STATE;
      end else begin
         stateFf <= nxtState;
      end
   end

   // outputs; the pll sees the rate one cycle after the frame that decided it
   assign regRdData      = stateFf.rdData;
   assign recClkRateSel  = stateFf.rate;
   assign refPllPreDiv   = stateFf.pDiv;
   assign refPllIntMul   = stateFf.jMul;
   assign refPllFracMul  = stateFf.dFrac;
   // an out-of-range J or D is held but flagged, the pll keeps its last good lock
   assign refPllCfgValid = (stateFf.jMul >= rx_status_pkg::REF_J_MIN)
                           && (stateFf.dFrac <= rx_status_pkg::REF_D_MAX);
   assign irq            = |(stateFf.evt & stateFf.mask);

   // checks
   // the burst flag is the decoder input of the previous cycle
   a_burst_flag: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 stateFf.nonpcm[0] == $past(burstDetect))
      else $error("burst flag does not follow detector");

   // a read of the detection register returns the burst flag as it stood
   a_burst_readback: assert property (@(posedge sys_clk) disable iff (srst)
      regRdEn && regAddr == rx_status_pkg::OFF_NONPCM_STAT
      |=> regRdData[0] == $past(stateFf.nonpcm[0]))
      else $error("burst flag read wrong");

   // a read of the detection register returns the surround flag as it stood
   a_surround_flag: assert property (@(posedge sys_clk) disable iff (srst)
      regRdEn && regAddr == rx_status_pkg::OFF_NONPCM_STAT
      |=> regRdData[1] == $past(stateFf.nonpcm[1]))
      else $error("surround flag read wrong");

   // the surround flag is the decoder input of the previous cycle
   a_surround_follow: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 stateFf.nonpcm[1] == $past(discSurroundDetect))
      else $error("surround flag does not follow detector");

   // a slow frame leaves room for the highest multiple
   a_rate_measure: assert property (@(posedge sys_clk) disable iff (srst)
      frameTick && !timedOut && stateFf.period >= CNT_W'(THR_512)
      |=> recClkRateSel == 2'b11)
      else $error("slow frame not reported as 512 fs");

   // the middle band of frame periods gives the middle multiple
   a_rate_256: assert property (@(posedge sys_clk) disable iff (srst)
      frameTick && !timedOut && stateFf.period >= CNT_W'(THR_256) && stateFf.period < CNT_W'(THR_512)
      |=> recClkRateSel == 2'b10)
      else $error("frame not reported as 256 fs");

   // the fastest serviceable frames only get the lowest multiple
   a_rate_128: assert property (@(posedge sys_clk) disable iff (srst)
      frameTick && !timedOut && stateFf.period >= CNT_W'(THR_128) && stateFf.period < CNT_W'(THR_256)
      |=> recClkRateSel == 2'b01)
      else $error("frame not reported as 128 fs");

   // frames too fast for any multiple leave the rate undetermined
   a_rate_fast: assert property (@(posedge sys_clk) disable iff (srst)
      frameTick && stateFf.period < CNT_W'(THR_128)
      |=> recClkRateSel == 2'b00)
      else $error("too fast a frame reported a rate");

   // a dead input falls back to undetermined
   a_rate_timeout: assert property (@(posedge sys_clk) disable iff (srst)
      timedOut && !frameTick ##1 !frameTick
      |-> recClkRateSel == 2'b00)
      else $error("rate not undetermined after timeout");

   // the status field and the pll selection are one register
   a_rate_readback: assert property (@(posedge sys_clk) disable iff (srst)
      regRdEn && regAddr == rx_status_pkg::OFF_RECCLK_STAT
      |=> regRdData[1:0] == $past(recClkRateSel))
      else $error("rate field differs from pll selection");

   // between frames the pll selection must not wander
   a_rate_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !frameTick && !timedOut
      |=> $stable(recClkRateSel))
      else $error("rate changed without a frame");

   // every new rate loaded into the field is reported to software
   a_rate_event: assert property (@(posedge sys_clk) disable iff (srst)
      $changed(recClkRateSel)
      |-> stateFf.evt[rx_status_pkg::BIT_EVT_RATE])
      else $error("rate change event missing");

   // an out-of-range multiplier is never offered as valid
   a_pll_range: assert property (@(posedge sys_clk) disable iff (srst)
      refPllIntMul == 6'h00 || refPllFracMul > 14'h270f
      |-> !refPllCfgValid)
      else $error("out of range pll setting flagged valid");

   // an in-range multiplier is offered as valid
   a_pll_valid: assert property (@(posedge sys_clk) disable iff (srst)
      refPllIntMul != 6'h00 && refPllFracMul <= 14'h270f
      |-> refPllCfgValid)
      else $error("in range pll setting flagged invalid");

   // first configuration byte carries P and the top of J
   a_pll_write: assert property (@(posedge sys_clk) disable iff (srst)
      regWrEn && regAddr == rx_status_pkg::OFF_REF_PLL_CFG1
      |=> refPllPreDiv == $past(regWrData[7:4]) && refPllIntMul[5:2] == $past(regWrData[3:0]))
      else $error("pre-divider write lost");

   // second configuration byte carries the bottom of J and the top of D
   a_pll_write_mid: assert property (@(posedge sys_clk) disable iff (srst)
      regWrEn && regAddr == rx_status_pkg::OFF_REF_PLL_CFG2
      |=> refPllIntMul[1:0] == $past(regWrData[7:6]) && refPllFracMul[13:8] == $past(regWrData[5:0]))
      else $error("middle configuration write lost");

   // third configuration byte carries the bottom of D
   a_pll_write_low: assert property (@(posedge sys_clk) disable iff (srst)
      regWrEn && regAddr == rx_status_pkg::OFF_REF_PLL_CFG3
      |=> refPllFracMul[7:0] == $past(regWrData))
      else $error("fraction write lost");

   // without a write the pll settings stay put
   a_pll_hold: assert property (@(posedge sys_clk) disable iff (srst)
      !regWrEn
      |=> $stable(refPllPreDiv) && $stable(refPllIntMul) && $stable(refPllFracMul))
      else $error("pll setting changed without a write");

   // the unused upper bits of both status registers read as zero
   a_ro_upper: assert property (@(posedge sys_clk) disable iff (srst)
      regRdEn && (regAddr == rx_status_pkg::OFF_NONPCM_STAT || regAddr == rx_status_pkg::OFF_RECCLK_STAT)
      |=> regRdData[7:2] == 6'h00)
      else $error("status upper bits not zero");

   // a write to the detection register cannot override the decoder
   a_ro_write: assert property (@(posedge sys_clk) disable iff (srst)
      regWrEn && regAddr == rx_status_pkg::OFF_NONPCM_STAT
      |=> stateFf.nonpcm == $past({discSurroundDetect, burstDetect}))
      else $error("write reached a read-only flag");

   // a rising burst flag sets its event and raises the line when unmasked
   a_evt_set: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(stateFf.nonpcm[0])
      |-> stateFf.evt[0] && (irq || !stateFf.mask[0]))
      else $error("burst change event missing");

   // writing a one clears the event when no new change arrives with it
   a_evt_clear: assert property (@(posedge sys_clk) disable iff (srst)
      regWrEn && regAddr == rx_status_pkg::OFF_EVENT_STAT && regWrData[0] && !evtHit[0]
      |=> !stateFf.evt[0])
      else $error("burst event not cleared");

   // main scenarios
   c_burst_seen: cover property (@(posedge sys_clk) disable iff (srst) $rose(stateFf.nonpcm[0]));
   c_surround_seen: cover property (@(posedge sys_clk) disable iff (srst) $rose(stateFf.nonpcm[1]));
   c_rate_512: cover property (@(posedge sys_clk) disable iff (srst) recClkRateSel == 2'b11);
   c_rate_256: cover property (@(posedge sys_clk) disable iff (srst) recClkRateSel == 2'b10);
   c_irq_raised: cover property (@(posedge sys_clk) disable iff (srst) $rose(irq));
endmodule

// >>> include/rx_status_pkg.sv
package rx_status_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_REF_PLL_CFG1  = 8'h0f;
   localparam logic [7:0] OFF_REF_PLL_CFG2  = 8'h10;
   localparam logic [7:0] OFF_REF_PLL_CFG3  = 8'h11;
   localparam logic [7:0] OFF_NONPCM_STAT   = 8'h12;
   localparam logic [7:0] OFF_RECCLK_STAT   = 8'h13;
   localparam logic [7:0] OFF_EVENT_STAT    = 8'h30;
   localparam logic [7:0] OFF_EVENT_MASK    = 8'h31;
   // field positions
   localparam int BIT_BURST_FMT    = 0;
   localparam int BIT_DISC_SURR    = 1;
   localparam int BIT_EVT_BURST    = 0;
   localparam int BIT_EVT_SURR     = 1;
   localparam int BIT_EVT_RATE     = 2;
   localparam int EVT_W            = 3;
   // reference pll limits and reset values (12.288 MHz reference)
   localparam logic [5:0]  REF_J_MIN       = 6'h01;
   localparam logic [13:0] REF_D_MAX       = 14'h270f;
   localparam logic [3:0]  REF_P_RST       = 4'h1;
   localparam logic [5:0]  REF_J_RST       = 6'h08;
   localparam logic [13:0] REF_D_RST       = 14'h0000;
   localparam logic [2:0]  EVT_MASK_RST    = 3'h0;
   // recovered clock rate codes
   typedef enum logic [1:0] {
      RATE_UNKNOWN = 2'b00,
      RATE_128FS   = 2'b01,
      RATE_256FS   = 2'b10,
      RATE_512FS   = 2'b11
   } rate_code_e;
   // timing
   localparam int CLK_KHZ            = 100000;
   localparam int FRAME_TIMEOUT_US   = 100;
   localparam int FRAME_TIMEOUT_CYC  = FRAME_TIMEOUT_US * CLK_KHZ / 1000;
   localparam int REC_CLK_MAX_KHZ    = 49152;
endpackage

// >>> testbench/stream_source_model.sv
`timescale 1ns/100ps
// stand-in for the stream decoder: frame ticks and format flags, all on sys_clk
module stream_source_model (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [15:0] framePeriod,
   input  wire logic        burstOn,
   input  wire logic        surrOn,
   output logic             burstDetect,
   output logic             discSurroundDetect,
   output logic             frameTick
);
   logic [15:0] cnt;
   logic        wrap;
   assign wrap = framePeriod != 16'h0000 && cnt == framePeriod - 16'h0001;
   // a zero period stops the stream, so the rate field has to time out
   always_ff @(posedge sys_clk) begin
      if (srst || wrap || framePeriod == 16'h0000)
         cnt <= 16'h0000;
      else
         cnt <= cnt + 16'h0001;
      frameTick <= !srst && wrap;
      burstDetect <= burstOn;
      discSurroundDetect <= surrOn;
   end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic        sys_clk, srst, regWrEn, regRdEn, burstOn, surrOn, refPllCfgValid, irq;
   logic        burstDetect, discSurroundDetect, frameTick;
   logic [7:0]  regAddr, regWrData, regRdData;
   logic [1:0]  recClkRateSel;
   logic [3:0]  refPllPreDiv;
   logic [5:0]  refPllIntMul;
   logic [13:0] refPllFracMul;
   logic [15:0] framePeriod;
   int          mismatches = 0;
   int          totalChecks = 0;
   int          cycles = 0;
   // reference table entries, then the range edges of the multiplier
   logic [3:0]  pTab[10] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1};
   logic [5:0]  jTab[10] = '{6'h0c, 6'h08, 6'h08, 6'h06, 6'h08, 6'h08, 6'h07, 6'h00, 6'h3f, 6'h08};
   logic [13:0] dTab[10] = '{14'h0000, 14'h1ba3, 14'h0000, 14'h0000, 14'h1ba3,
                             14'h0000, 14'h0b02, 14'h0000, 14'h270f, 14'h2710};
   // fast to slow, so the final timeout has to pull a live rate back to undetermined
   logic [15:0] nTab[6] = '{16'h0064, 16'h012c, 16'h0209, 16'h0411, 16'h0412, 16'h07d0};

   receiver_stream_status_regs #(.FRAME_TIMEOUT(3000)) receiver_stream_status_regs_i (.sys_clk, .srst,
      .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .burstDetect, .discSurroundDetect, .frameTick,
      .recClkRateSel, .refPllPreDiv, .refPllIntMul, .refPllFracMul, .refPllCfgValid, .irq);
   stream_source_model stream_source_model_i (.sys_clk, .srst, .framePeriod, .burstOn, .surrOn,
      .burstDetect, .discSurroundDetect, .frameTick);

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // rate thresholds by frame period in clock cycles
   function automatic logic [1:0] expRate(input logic [15:0] n);
      return n >= 16'd1042 ? 2'b11 : n >= 16'd521 ? 2'b10 : n >= 16'd261 ? 2'b01 : 2'b00;
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask
   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1 cmp(regRdData, e);
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, well above the longest frame sweep
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         give_verdict;
      end
   end
   // main sequence
   initial begin
      srst = 1'b1;
      {regAddr, regWrData, regWrEn, regRdEn, burstOn, surrOn, framePeriod} = '0;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      rd(8'h0f, 8'h12);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h00);
      for (int i = 0; i < 10; i++) begin
         wr(8'h0f, {pTab[i][3:0], jTab[i][5:2]});
         wr(8'h10, {jTab[i][1:0], dTab[i][13:8]});
         wr(8'h11, dTab[i][7:0]);
         waitCyc(1);
         cmp({refPllPreDiv, refPllIntMul}, {pTab[i][3:0], jTab[i][5:0]});
         cmp(refPllFracMul, dTab[i]);
         cmp(refPllCfgValid, jTab[i] != 6'h00 && dTab[i] <= 14'h270f);
      end
      wr(8'h12, 8'hff);
      wr(8'h13, 8'hff);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h00);
      rd(8'h7f, 8'h00);
      // flags with the interrupt raised, cleared and masked
      wr(8'h31, 8'h01);
      burstOn <= 1'b1;
      waitCyc(3);
      rd(8'h12, 8'h01);
      cmp(irq, 1'b1);
      surrOn <= 1'b1;
      waitCyc(3);
      rd(8'h12, 8'h03);
      rd(8'h30, 8'h03);
      wr(8'h30, 8'h01);
      waitCyc(1);
      cmp(irq, 1'b0);
      rd(8'h30, 8'h02);
      burstOn <= 1'b0;
      waitCyc(3);
      rd(8'h12, 8'h02);
      cmp(irq, 1'b1);
      wr(8'h31, 8'h00);
      waitCyc(1);
      cmp(irq, 1'b0);
      // frame period sweep across the rate thresholds
      for (int i = 0; i < 6; i++) begin
         framePeriod <= nTab[i];
         waitCyc(3 * nTab[i]);
         cmp(recClkRateSel, expRate(nTab[i]));
         rd(8'h13, {6'h00, expRate(nTab[i])});
      end
      framePeriod <= 16'h0000;
      waitCyc(3100);
      cmp(recClkRateSel, 2'b00);
      rd(8'h13, 8'h00);
      // every rate change left its event behind; unmasking it raises the line
      rd(8'h30, 8'h07);
      wr(8'h31, 8'h04);
      waitCyc(1);
      cmp(irq, 1'b1);
      give_verdict;
   end
endmodule
